// ===== tb/board_hub_model.sv
// Purpose: Board straps, strap terminations, PLL lock and platform hub reset facing the sampler.
// Assumes: The bench sets the wanted levels on ref_clk_i edges.
// Notes:   A floating strap toggles every cycle, so a sampler that trusts the pin level cannot pass.
`timescale 1ns/1ps
module board_hub_model
    import strap_cfg_pkg::*;
(
    input  wire logic                              ref_clk_i,
    input  wire logic                              hub_rst_i,
    input  wire logic [strap_cfg_pkg::STRAP_W-1:0] strap_i,
    input  wire logic [strap_cfg_pkg::STRAP_W-1:0] term_i,
    input  wire logic                              lock_i,
    output logic                                   platform_rst_n_o,
    output logic [strap_cfg_pkg::STRAP_W-1:0]      cfg_strap_o,
    output logic [strap_cfg_pkg::STRAP_W-1:0]      cfg_strap_term_o,
    output logic                                   pll_locked_o
);
    logic float_q = 1'b0;

    always_ff @(posedge ref_clk_i) begin
        float_q <= ~float_q;
    end

    assign platform_rst_n_o = ~hub_rst_i;
    // The stall strap is released by the bench while the sequence waits.
    assign cfg_strap_o      = (strap_i & term_i) | (~term_i & {STRAP_W{float_q}});
    assign cfg_strap_term_o = term_i;
    assign pll_locked_o     = lock_i;
endmodule

// ===== tb/reset_strap_config_sampler_tb_top.sv
// Purpose: Self-checking bench for the strap sampler and its register port.
// Assumes: 250 MHz clock; the board model drives straps and platform reset.
// Notes:   Waits after platform release cover the two-flop synchronisers with margin.
`timescale 1ns/1ps
module reset_strap_config_sampler_tb_top;
    import strap_cfg_pkg::*;
    logic               ref_clk_i, nrst_i = 1'b0, hub_rst = 1'b1, lock = 1'b0, plat_n, pll_lk;
    logic [STRAP_W-1:0] strap_v = '1, term_v = '1, pin_v, pin_t;
    logic               go, lane, edp, train;
    logic [1:0]         bif, bresp, rresp;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0]  awaddr = '0, araddr = '0;
    logic [DATA_W-1:0]  wdata = '0, rdata;
    int                 fail_count = 0, checks = 0;

    board_hub_model u_board (.ref_clk_i(ref_clk_i), .hub_rst_i(hub_rst), .strap_i(strap_v), .term_i(term_v),
        .lock_i(lock), .platform_rst_n_o(plat_n), .cfg_strap_o(pin_v), .cfg_strap_term_o(pin_t),
        .pll_locked_o(pll_lk));

    reset_strap_config_sampler dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .platform_rst_n_i(plat_n),
        .cfg_strap_i(pin_v), .cfg_strap_term_i(pin_t), .pll_locked_i(pll_lk), .reset_seq_go_o(go),
        .lane_reverse_o(lane), .edp_enable_o(edp), .bifurcation_o(bif), .link_train_o(train),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= d;
        bready  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) chk(1'b0, 1'b1);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50) chk(1'b0, 1'b1);
    endtask

    task automatic boot(input logic [19:0] s, input logic [19:0] t);
        @(posedge ref_clk_i);
        hub_rst <= 1'b1;
        strap_v <= s;
        term_v  <= t;
        repeat (8) @(posedge ref_clk_i);
        chk(train, 1'b0);
        hub_rst <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
    endtask

    task automatic check_set(input logic [19:0] s);
        chk(lane, !s[2]);
        chk(edp, !s[4]);
        chk(bif, s[6:5]);
        chk(train, s[7]);
    endtask

    task automatic test_stall;
        @(posedge ref_clk_i);
        strap_v <= 20'hffffe;
        repeat (4) @(posedge ref_clk_i);
        lock <= 1'b1;
        boot(20'hffffe, 20'hfffff);
        chk(go, 1'b0);
        chk(train, 1'b0);
        strap_v[0] <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk(go, 1'b1);
        chk(train, 1'b1);
        $display("stall test done");
    endtask

    task automatic test_straps;
        logic [19:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            s = 20'hfffff;
            s[6:5] = i[1:0];
            s[2] = i[0];
            s[4] = i[1];
            boot(s, 20'hfffff);
            check_set(s);
            axi_rd(STRAPS_OFS, d, r);
            chk(d, {12'h000, s});
            strap_v <= ~s | 20'h00001;
            repeat (8) @(posedge ref_clk_i);
            check_set(s);
        end
        $display("strap decode test done");
    endtask

    task automatic test_float;
        logic [31:0] d;
        logic [1:0]  r;
        boot(20'h00001, 20'h00001);
        check_set(20'hfffff);
        axi_rd(STRAPS_OFS, d, r);
        chk(d, 32'h000fffff);
        $display("floating strap test done");
    endtask

    task automatic test_fw;
        logic [31:0] d;
        logic [1:0]  r;
        boot(20'hfff7f, 20'hfffff);
        chk(train, 1'b0);
        axi_rd(STATUS_OFS, d, r);
        chk(d, 32'h00000027);
        axi_wr(CTRL_OFS, 32'h00000001, r);
        chk(r, RESP_OKAY);
        repeat (4) @(posedge ref_clk_i);
        chk(train, 1'b1);
        axi_rd(STATUS_OFS, d, r);
        chk(d, 32'h0000002f);
        axi_rd(CTRL_OFS, d, r);
        chk(d, 32'h00000001);
        axi_rd(8'h10, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h00000000);
        axi_wr(8'h0c, 32'h00000001, r);
        chk(r, RESP_SLVERR);
        $display("firmware start test done");
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        test_stall;
        test_straps;
        test_float;
        test_fw;
        report_and_stop;
    end

    // The tests need well under a thousand cycles; the margin covers slow answers.
    initial begin
        #20000;
        fail_count++;
        report_and_stop;
    end
endmodule

// ===== verilog/reset_strap_config_sampler.sv
// Purpose: Samples board straps while the platform hub holds reset and turns them into static settings.
// Assumes: Strap, termination and platform reset pins are asynchronous; the PLL lock flag is on ref_clk_i.
// Notes:   Strap pins cannot float in a netlist, so each strap has a termination-present pin beside it.
// How it works
// - Unterminated strap reads as logic one.
// - Stall strap low halts sequence after lock.
// - Strap two low reverses x16 lane numbers.
// - Strap four low enables embedded display.
// - Two-bit field selects link bifurcation.
// - Strap seven high trains after reset release.
// - Strap seven low waits for firmware start.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module reset_strap_config_sampler
    import strap_cfg_pkg::*;
(
    input  wire logic                                 ref_clk_i,
    input  wire logic                                 nrst_i,
    input  wire logic                                 platform_rst_n_i,
    input  wire logic [strap_cfg_pkg::STRAP_W-1:0]    cfg_strap_i,
    input  wire logic [strap_cfg_pkg::STRAP_W-1:0]    cfg_strap_term_i,
    input  wire logic                                 pll_locked_i,
    output logic                                      reset_seq_go_o,
    output logic                                      lane_reverse_o,
    output logic                                      edp_enable_o,
    output logic [1:0]                                bifurcation_o,
    output logic                                      link_train_o,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [strap_cfg_pkg::ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]                           s_axi_awprot,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    input  wire logic [strap_cfg_pkg::DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    output logic [1:0]                                s_axi_bresp,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    input  wire logic [strap_cfg_pkg::ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]                           s_axi_arprot,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    output logic [strap_cfg_pkg::DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                                s_axi_rresp
);
    import strap_cfg_pkg::*;

    typedef struct packed {
        logic               rst_m;
        logic               rst_s;
        logic               rst_prev;
        logic [STRAP_W-1:0] cfg_m;
        logic [STRAP_W-1:0] cfg_s;
        logic [STRAP_W-1:0] term_m;
        logic [STRAP_W-1:0] term_s;
        logic [STRAP_W-1:0] straps;
        logic               go;
        link_e              link;
        logic               fw_req;
        logic               train;
        logic               lane_rev;
        logic               edp_en;
        logic [1:0]         bif;
        logic               awready;
        logic               wready;
        logic               aw_have;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_have;
        logic [DATA_W-1:0]  w_data;
        logic [3:0]         w_strb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [DATA_W-1:0]  rdata;
        logic [1:0]         rresp;
    } state_s;

    localparam state_s STATE_RST = '{
        rst_m: 1'b0, rst_s: 1'b0, rst_prev: 1'b0,
        cfg_m: STRAP_RST, cfg_s: STRAP_RST, term_m: '0, term_s: '0, straps: STRAP_RST,
        go: 1'b0, link: LINK_HELD, fw_req: 1'b0, train: 1'b0,
        lane_rev: 1'b0, edp_en: 1'b0, bif: BIF_X16,
        awready: 1'b0, wready: 1'b0, aw_have: 1'b0, aw_addr: '0,
        w_have: 1'b0, w_data: '0, w_strb: '0, bvalid: 1'b0, bresp: RESP_OKAY,
        arready: 1'b0, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY
    };

    state_s q;
    state_s d;

    // Maps a byte address onto a register selector; 2'h3 marks an unmapped address.
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [1:0] sel;
        sel = 2'h3;
        if (addr == CTRL_OFS) begin
            sel = 2'h0;
        end else if (addr == STATUS_OFS) begin
            sel = 2'h1;
        end else if (addr == STRAPS_OFS) begin
            sel = 2'h2;
        end
        return sel;
    endfunction

    logic [STRAP_W-1:0] strap_eff;
    logic               plat_up;
    logic               plat_release;
    logic               fw_start;
    logic               do_write;

    always_comb begin
        d = q;
        fw_start = 1'b0;
        do_write = 1'b0;

        // Two-stage synchronisers for the platform reset, strap and termination pins; PLL lock is used as is.
        d.rst_m  = platform_rst_n_i;
        d.rst_s  = q.rst_m;
        d.cfg_m  = cfg_strap_i;
        d.cfg_s  = q.cfg_m;
        d.term_m = cfg_strap_term_i;
        d.term_s = q.term_m;
        d.rst_prev = q.rst_s;

        strap_eff    = q.cfg_s | ~q.term_s;
        plat_up      = q.rst_s;
        plat_release = q.rst_s & ~q.rst_prev;

        // Straps follow the pins while the hub holds reset and freeze once it lets go.
        if (!plat_up) begin
            d.straps = strap_eff;
        end

        // The stall strap is watched live so that releasing it ends the stall.
        if (pll_locked_i && strap_eff[STALL_BIT]) begin
            d.go = 1'b1;
        end

        d.lane_rev = ~q.straps[LANE_BIT];
        d.edp_en   = ~q.straps[EDP_BIT];
        d.bif      = q.straps[BIF_LO+1:BIF_LO];

        // AXI4-Lite write path: address and data are taken in either order.
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            do_write  = 1'b1;
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = (reg_sel(q.aw_addr) == 2'h3) ? RESP_SLVERR : RESP_OKAY;
            if (reg_sel(q.aw_addr) == 2'h0 && q.w_strb[0] && q.w_data[CTRL_FW_START]) begin
                fw_start = 1'b1;
            end
        end
        d.awready = ~d.aw_have & ~d.bvalid;
        d.wready  = ~d.w_have & ~d.bvalid;

        // AXI4-Lite read path.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = '0;
            unique case (reg_sel(s_axi_araddr))
                2'h0: begin
                    d.rdata[CTRL_FW_START] = q.fw_req;
                end
                2'h1: begin
                    d.rdata[STAT_SEQ_GO]                     = q.go;
                    d.rdata[STAT_PLAT_UP]                    = plat_up;
                    d.rdata[STAT_LINK_LO+1:STAT_LINK_LO]     = q.link;
                    d.rdata[STAT_BIF_RSVD]                   = (q.bif == BIF_RSVD);
                    d.rdata[STAT_STALL_LIVE]                 = strap_eff[STALL_BIT];
                end
                2'h2: begin
                    d.rdata[STRAP_W-1:0] = q.straps;
                end
                2'h3: begin
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        d.arready = ~d.rvalid;

        // A firmware start request is remembered; a start arriving with the reset wins.
        if (!plat_up) begin
            d.fw_req = fw_start;
        end else if (fw_start) begin
            d.fw_req = 1'b1;
        end

        // Link training sequencer.
        unique case (q.link)
            LINK_HELD: begin
                if (plat_up && q.go) begin
                    d.link = q.straps[TRAIN_BIT] ? LINK_TRAIN : LINK_WAIT_FW;
                end
            end
            LINK_WAIT_FW: begin
                if (q.fw_req || fw_start) begin
                    d.link = LINK_TRAIN;
                end
            end
            LINK_TRAIN: begin
                d.link = LINK_TRAIN;
            end
            default: begin
                d.link = LINK_HELD;
            end
        endcase
        if (!plat_up) begin
            d.link = LINK_HELD;
        end
        d.train = (d.link == LINK_TRAIN);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign reset_seq_go_o = q.go;
    assign lane_reverse_o = q.lane_rev;
    assign edp_enable_o   = q.edp_en;
    assign bifurcation_o  = q.bif;
    assign link_train_o   = q.train;
    assign s_axi_awready  = q.awready;
    assign s_axi_wready   = q.wready;
    assign s_axi_bvalid   = q.bvalid;
    assign s_axi_bresp    = q.bresp;
    assign s_axi_arready  = q.arready;
    assign s_axi_rvalid   = q.rvalid;
    assign s_axi_rdata    = q.rdata;
    assign s_axi_rresp    = q.rresp;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence plat_held_s;
        !q.rst_s [*4];
    endsequence

    sequence plat_steady_s;
        q.rst_s && $past(q.rst_s);
    endsequence

    a_strap_unterm: assert property (
        plat_held_s |-> q.straps == $past(cfg_strap_i | ~cfg_strap_term_i, 3))
        else $error("Latched strap does not match pin with termination default.");

    a_stall_holds: assert property (
        !reset_seq_go_o && !q.cfg_s[STALL_BIT] && q.term_s[STALL_BIT] |=> !reset_seq_go_o)
        else $error("Reset sequence left the stall while the stall strap was low.");

    a_go_on_lock: assert property (
        pll_locked_i && strap_eff[STALL_BIT] |=> reset_seq_go_o)
        else $error("Reset sequence did not proceed after lock with stall released.");

    a_lane_order: assert property (
        plat_steady_s ##1 1'b1 |-> lane_reverse_o == !q.straps[LANE_BIT])
        else $error("Lane reversal output disagrees with latched strap.");

    a_edp_enable: assert property (
        plat_steady_s ##1 1'b1 |-> edp_enable_o == !q.straps[EDP_BIT])
        else $error("Display enable output disagrees with latched strap.");

    a_bif_field: assert property (
        plat_steady_s ##1 1'b1 |-> bifurcation_o == q.straps[BIF_LO+1:BIF_LO])
        else $error("Bifurcation output disagrees with latched strap field.");

    a_train_auto: assert property (
        plat_release && q.go && q.straps[TRAIN_BIT] && q.link == LINK_HELD |-> ##1 link_train_o)
        else $error("Link training did not start right after platform reset release.");

    a_train_waits: assert property (
        q.link == LINK_WAIT_FW && !q.fw_req && !fw_start |=> !link_train_o)
        else $error("Link training started without a firmware request.");

    a_no_train_rst: assert property (
        !q.rst_s |=> !link_train_o)
        else $error("Link training active while platform reset is asserted.");

    a_straps_frozen: assert property (
        plat_steady_s |-> $stable(q.straps))
        else $error("Latched straps changed after platform reset release.");

    a_write_answer: assert property (
        do_write |=> s_axi_bvalid)
        else $error("Write response missing one cycle after address and data.");

endmodule

// ===== verilog/strap_cfg_pkg.sv
// Purpose: Shared constants and types for the reset-time strap configuration sampler.
// Assumes: One core clock at 250 MHz; registers reached over AXI4-Lite with 32-bit data.
// Notes:   Strap values after reset are all ones, the board default when nothing drives a strap.
package strap_cfg_pkg;

    localparam int unsigned STRAP_W    = 20;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STRAPS_OFS = 8'h08;

    // Strap bit positions.
    localparam int unsigned STALL_BIT  = 0;
    localparam int unsigned LANE_BIT   = 2;
    localparam int unsigned EDP_BIT    = 4;
    localparam int unsigned BIF_LO     = 5;
    localparam int unsigned TRAIN_BIT  = 7;

    // Register field positions.
    localparam int unsigned CTRL_FW_START   = 0;
    localparam int unsigned STAT_SEQ_GO     = 0;
    localparam int unsigned STAT_PLAT_UP    = 1;
    localparam int unsigned STAT_LINK_LO    = 2;
    localparam int unsigned STAT_BIF_RSVD   = 4;
    localparam int unsigned STAT_STALL_LIVE = 5;

    // Strap value after reset and AXI response codes.
    localparam logic [STRAP_W-1:0] STRAP_RST = 20'hfffff;
    localparam logic [1:0]         RESP_OKAY   = 2'h0;
    localparam logic [1:0]         RESP_SLVERR = 2'h2;

    // Bifurcation field codes.
    localparam logic [1:0] BIF_X8_2X4 = 2'h0;
    localparam logic [1:0] BIF_RSVD   = 2'h1;
    localparam logic [1:0] BIF_2X8    = 2'h2;
    localparam logic [1:0] BIF_X16    = 2'h3;

    typedef enum logic [1:0] {
        LINK_HELD    = 2'h0,
        LINK_WAIT_FW = 2'h1,
        LINK_TRAIN   = 2'h3
    } link_e;

endpackage
